// ==== rpmss_far_model.sv ====
// Far-side model: flash security bytes and core sleep requests
`timescale 1ns/1ps
`default_nettype none
module rpmss_far_model
   import rpmss_pkg::*;
(
   input wire logic clk_in,
   input wire logic secure_in,
   input wire logic [15:0] key_in,
   input wire logic stop_cmd_in,
   input wire logic wait_cmd_in,
   output logic [15:0] sec_bytes_out,
   output logic stop_req_out,
   output logic wait_req_out
);
   logic osc_sel_r;
   ////////////////////////////////////////
   // Secured bytes never equal the unsecured code
   assign sec_bytes_out = !secure_in ? RPMSS_UNSEC_WORD : (key_in == RPMSS_UNSEC_WORD) ? 16'h0000 : key_in;
   // Clock moved to oscillator, PLL off, one cycle before stop
   always_ff @(posedge clk_in) begin
      osc_sel_r <= stop_cmd_in;
   end
   assign stop_req_out = stop_cmd_in & osc_sel_r;
   assign wait_req_out = wait_cmd_in;
endmodule
`default_nettype wire

// ==== rpmss_pkg.sv ====
// Constants and types for the reset, power mode and security sequencer
// How it works
// - Run mode keeps core and peripheral clocks
// - Wait gates core clocks, peripherals keep running
// - Unmasked peripheral interrupt wakes from wait
// - Stop exits only on listed wake sources
// - Waking CAN frame is dropped, later kept
// - Peripherals except watchdog use peripheral bus clock
// - Software can disable stop and wait instructions
// - Permanent disable holds until any reset
// - Four reset sources, two async, two sync
// - Control register write makes software reset
// - Power-on reset stretched 2097152 cycles
// - Then 32 cycles starting integration clocks
// - Then 32 cycles releasing peripherals, security
// - Then 32 cycles initialising core, then fetch
// - Reset released synchronously on clock rising edge
// - Security from two nonvolatile flash bytes
// - Secured blocks external program, boot, debug
// - Secured boots internally at 0x02_0000
// - Secured ignores external boot strap
// - Debug read disable driven from security bytes
// - Test access port active whatever security
package rpmss_pkg;
   localparam logic [31:0] RPMSS_CTRL_ADDR = 32'h0000_0000;
   localparam logic [31:0] RPMSS_STAT_ADDR = 32'h0000_0004;
   localparam int RPMSS_ADDR_W = 4;
   localparam int RPMSS_BIT_WAIT_DIS = 0;
   localparam int RPMSS_BIT_STOP_DIS = 1;
   localparam int RPMSS_BIT_PERM = 2;
   localparam int RPMSS_BIT_SWRST = 3;
   localparam int RPMSS_STAT_MODE_LSB = 0;
   localparam int RPMSS_STAT_SEC_BIT = 2;
   localparam int RPMSS_STAT_BOOT_LSB = 3;
   localparam int RPMSS_STAGE_CYC = 32;
   localparam int RPMSS_POR_CYC = 2097152;
   localparam int RPMSS_CNT_W = 22;
   localparam logic [15:0] RPMSS_UNSEC_WORD = 16'he70a;
   localparam logic [23:0] RPMSS_SEC_BOOT_ADDR = 24'h02_0000;
   localparam logic [23:0] RPMSS_INT_BOOT_ADDR = 24'h00_0000;
   localparam logic [23:0] RPMSS_EXT_BOOT_ADDR = 24'h00_0000;
   localparam logic [1:0] RPMSS_HTRANS_NONSEQ = 2'h2;
   typedef enum {RPMSS_RST_POR, RPMSS_RST_CLK, RPMSS_RST_PERIPH, RPMSS_RST_CORE, RPMSS_RST_DONE} rpmss_rst_t;
   typedef enum {RPMSS_RUN, RPMSS_WAIT, RPMSS_STOP} rpmss_mode_t;
   typedef enum {RPMSS_BOOT_INT, RPMSS_BOOT_EXT, RPMSS_BOOT_SEC} rpmss_boot_t;
endpackage

// ==== rpmss_top.sv ====
// Reset, power mode and flash security sequencer
`timescale 1ns/1ps
`default_nettype none
module rpmss_top
   import rpmss_pkg::*;
#(
   parameter int POR_CYCLES = RPMSS_POR_CYC
) (
   input wire logic CLK_IN,
   input wire logic NRST_IN,
   input wire logic POR_N_IN,
   input wire logic WDOG_RST_IN,
   input wire logic EXT_BOOT_STRAP_IN,
   input wire logic [15:0] SEC_BYTES_IN,
   input wire logic STOP_REQ_IN,
   input wire logic WAIT_REQ_IN,
   input wire logic PERIPH_IRQ_IN,
   input wire logic NCLK_IRQ_IN,
   input wire logic CAN_ACT_IN,
   input wire logic HSEL_IN,
   input wire logic [31:0] HADDR_IN,
   input wire logic [1:0] HTRANS_IN,
   input wire logic HWRITE_IN,
   input wire logic [2:0] HSIZE_IN,
   input wire logic [31:0] HWDATA_IN,
   input wire logic HREADY_IN,
   output logic [31:0] HRDATA_OUT,
   output logic HREADYOUT_OUT,
   output logic HRESP_OUT,
   output logic CORE_CLK_EN_OUT,
   output logic PERIPH_CLK_EN_OUT,
   output logic SYSINT_CLK_EN_OUT,
   output logic PERIPH_RST_N_OUT,
   output logic CORE_RST_N_OUT,
   output logic CAN_DROP_OUT,
   output logic SECURE_OUT,
   output logic EXT_PSPACE_EN_OUT,
   output logic DEBUG_EN_OUT,
   output logic DBG_RD_DIS_OUT,
   output logic TAP_EN_OUT,
   output logic [1:0] BOOT_MODE_OUT,
   output logic [23:0] BOOT_ADDR_OUT
);

////////////////////////////////////////////////////////////////////////////////
// Reset merge and synchronous release
logic por_s1_r, por_s2_r, rst_s1_r, rst_s2_r;
logic swrst_r;
logic sync_rst_n;
logic ext_n;
assign ext_n = NRST_IN & POR_N_IN;
always_ff @(posedge CLK_IN or negedge POR_N_IN) begin
   if (!POR_N_IN) begin
      por_s1_r <= 1'b0;
      por_s2_r <= 1'b0;
   end else begin
      por_s1_r <= 1'b1;
      por_s2_r <= por_s1_r;
   end
end
always_ff @(posedge CLK_IN or negedge ext_n) begin
   if (!ext_n) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
   end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
   end
end
assign sync_rst_n = rst_s2_r & ~WDOG_RST_IN & ~swrst_r;

////////////////////////////////////////////////////////////////////////////////
// Staged release sequencer
rpmss_rst_t seq_r, seq_nxt;
logic [RPMSS_CNT_W-1:0] cnt_r, cnt_nxt;
logic por_done_r;
always_comb begin
   seq_nxt = seq_r;
   cnt_nxt = cnt_r + 1'b1;
   case (seq_r)
      RPMSS_RST_POR: begin
         if (por_done_r || cnt_r == RPMSS_CNT_W'(POR_CYCLES - 1)) begin
            seq_nxt = RPMSS_RST_CLK;
            cnt_nxt = '0;
         end
      end
      RPMSS_RST_CLK: begin
         if (cnt_r == RPMSS_CNT_W'(RPMSS_STAGE_CYC - 1)) begin
            seq_nxt = RPMSS_RST_PERIPH;
            cnt_nxt = '0;
         end
      end
      RPMSS_RST_PERIPH: begin
         if (cnt_r == RPMSS_CNT_W'(RPMSS_STAGE_CYC - 1)) begin
            seq_nxt = RPMSS_RST_CORE;
            cnt_nxt = '0;
         end
      end
      RPMSS_RST_CORE: begin
         if (cnt_r == RPMSS_CNT_W'(RPMSS_STAGE_CYC - 1)) begin
            seq_nxt = RPMSS_RST_DONE;
            cnt_nxt = '0;
         end
      end
      RPMSS_RST_DONE: begin
         cnt_nxt = '0;
      end
      default: begin
         seq_nxt = RPMSS_RST_POR;
         cnt_nxt = '0;
      end
   endcase
end
always_ff @(posedge CLK_IN or negedge por_s2_r) begin
   if (!por_s2_r) begin
      por_done_r <= 1'b0;
   end else if (seq_r == RPMSS_RST_CLK) begin
      por_done_r <= 1'b1; // Later resets other than power-on skip the stretch
   end
end
always_ff @(posedge CLK_IN or negedge ext_n) begin
   if (!ext_n) begin
      seq_r <= RPMSS_RST_POR;
      cnt_r <= '0;
   end else if (!sync_rst_n) begin
      seq_r <= RPMSS_RST_POR;
      cnt_r <= '0;
   end else begin
      seq_r <= seq_nxt;
      cnt_r <= cnt_nxt;
   end
end
assign SYSINT_CLK_EN_OUT = (seq_r != RPMSS_RST_POR);
assign PERIPH_RST_N_OUT = (seq_r == RPMSS_RST_CORE) || (seq_r == RPMSS_RST_DONE);
assign CORE_RST_N_OUT = (seq_r == RPMSS_RST_DONE);

////////////////////////////////////////////////////////////////////////////////
// Security capture and boot selection
logic secure_r, strap_r, sec_taken_r;
always_ff @(posedge CLK_IN or negedge ext_n) begin
   if (!ext_n) begin
      secure_r <= 1'b1;
      strap_r <= 1'b0;
      sec_taken_r <= 1'b0;
   end else if (!sync_rst_n) begin
      sec_taken_r <= 1'b0;
   end else if (seq_r == RPMSS_RST_PERIPH && !sec_taken_r) begin
      secure_r <= (SEC_BYTES_IN != RPMSS_UNSEC_WORD);
      strap_r <= EXT_BOOT_STRAP_IN;
      sec_taken_r <= 1'b1;
   end
end
rpmss_boot_t boot_mode;
always_comb begin
   if (secure_r) begin
      boot_mode = RPMSS_BOOT_SEC;
   end else if (strap_r) begin
      boot_mode = RPMSS_BOOT_EXT;
   end else begin
      boot_mode = RPMSS_BOOT_INT;
   end
end
assign SECURE_OUT = secure_r;
assign BOOT_MODE_OUT = 2'(boot_mode);
assign BOOT_ADDR_OUT = (boot_mode == RPMSS_BOOT_SEC) ? RPMSS_SEC_BOOT_ADDR :
   (boot_mode == RPMSS_BOOT_EXT) ? RPMSS_EXT_BOOT_ADDR : RPMSS_INT_BOOT_ADDR;
assign EXT_PSPACE_EN_OUT = ~secure_r;
assign DEBUG_EN_OUT = ~secure_r;
assign DBG_RD_DIS_OUT = secure_r;
assign TAP_EN_OUT = 1'b1;

////////////////////////////////////////////////////////////////////////////////
// Bus slave and control register
logic [RPMSS_ADDR_W-1:0] ap_addr_r;
logic ap_wr_r, ap_rd_r;
logic wait_dis_r, stop_dis_r, perm_r;
logic [31:0] rdata;
logic ap_valid;
assign ap_valid = HSEL_IN & HREADY_IN & (HTRANS_IN == RPMSS_HTRANS_NONSEQ);
assign HREADYOUT_OUT = 1'b1;
assign HRESP_OUT = 1'b0;
always_ff @(posedge CLK_IN or negedge ext_n) begin
   if (!ext_n) begin
      ap_addr_r <= '0;
      ap_wr_r <= 1'b0;
      ap_rd_r <= 1'b0;
   end else begin
      ap_addr_r <= HADDR_IN[RPMSS_ADDR_W-1:0];
      ap_wr_r <= ap_valid & HWRITE_IN;
      ap_rd_r <= ap_valid & ~HWRITE_IN;
   end
end
always_ff @(posedge CLK_IN or negedge ext_n) begin
   if (!ext_n) begin
      wait_dis_r <= 1'b0;
      stop_dis_r <= 1'b0;
      perm_r <= 1'b0;
      swrst_r <= 1'b0;
   end else if (!sync_rst_n) begin
      wait_dis_r <= 1'b0;
      stop_dis_r <= 1'b0;
      perm_r <= 1'b0;
      swrst_r <= 1'b0;
   end else if (ap_wr_r && ap_addr_r == RPMSS_CTRL_ADDR[RPMSS_ADDR_W-1:0]) begin
      swrst_r <= HWDATA_IN[RPMSS_BIT_SWRST];
      if (!perm_r) begin
         wait_dis_r <= HWDATA_IN[RPMSS_BIT_WAIT_DIS];
         stop_dis_r <= HWDATA_IN[RPMSS_BIT_STOP_DIS];
         perm_r <= HWDATA_IN[RPMSS_BIT_PERM];
      end
   end
end
rpmss_mode_t mode_r;
always_comb begin
   rdata = '0;
   if (ap_addr_r == RPMSS_CTRL_ADDR[RPMSS_ADDR_W-1:0]) begin
      rdata[RPMSS_BIT_WAIT_DIS] = wait_dis_r;
      rdata[RPMSS_BIT_STOP_DIS] = stop_dis_r;
      rdata[RPMSS_BIT_PERM] = perm_r;
   end else if (ap_addr_r == RPMSS_STAT_ADDR[RPMSS_ADDR_W-1:0]) begin
      rdata[RPMSS_STAT_MODE_LSB +: 2] = 2'(mode_r);
      rdata[RPMSS_STAT_SEC_BIT] = secure_r;
      rdata[RPMSS_STAT_BOOT_LSB +: 2] = 2'(boot_mode);
   end
end
always_ff @(posedge CLK_IN or negedge ext_n) begin
   if (!ext_n) begin
      HRDATA_OUT <= '0;
   end else begin
      HRDATA_OUT <= (ap_valid & ~HWRITE_IN) ? 32'h0000_0000 : HRDATA_OUT;
      if (ap_rd_r) begin
         HRDATA_OUT <= rdata;
      end
   end
end

////////////////////////////////////////////////////////////////////////////////
// Power modes
logic can_drop_r;
always_ff @(posedge CLK_IN or negedge ext_n) begin
   if (!ext_n) begin
      mode_r <= RPMSS_RUN;
      can_drop_r <= 1'b0;
   end else if (!sync_rst_n) begin
      mode_r <= RPMSS_RUN;
      can_drop_r <= 1'b0;
   end else begin
      case (mode_r)
         RPMSS_RUN: begin
            can_drop_r <= can_drop_r & CAN_ACT_IN;
            if (CORE_RST_N_OUT && STOP_REQ_IN && !stop_dis_r) begin
               mode_r <= RPMSS_STOP;
            end else if (CORE_RST_N_OUT && WAIT_REQ_IN && !wait_dis_r) begin
               mode_r <= RPMSS_WAIT;
            end
         end
         RPMSS_WAIT: begin
            if (PERIPH_IRQ_IN) begin
               mode_r <= RPMSS_RUN;
            end
         end
         RPMSS_STOP: begin
            if (CAN_ACT_IN || NCLK_IRQ_IN) begin
               mode_r <= RPMSS_RUN;
               can_drop_r <= CAN_ACT_IN;
            end
         end
         default: begin
            mode_r <= RPMSS_RUN;
         end
      endcase
   end
end
assign CAN_DROP_OUT = can_drop_r;
assign CORE_CLK_EN_OUT = CORE_RST_N_OUT && (mode_r == RPMSS_RUN);
assign PERIPH_CLK_EN_OUT = SYSINT_CLK_EN_OUT && (mode_r != RPMSS_STOP);

////////////////////////////////////////////////////////////////////////////////
// Assertions

// Cycles spent in the current release stage
logic [RPMSS_CNT_W-1:0] chk_len_r;
rpmss_rst_t chk_seq_r;
always_ff @(posedge CLK_IN or negedge ext_n) begin
   if (!ext_n) begin
      chk_seq_r <= RPMSS_RST_POR;
      chk_len_r <= '0;
   end else begin
      chk_seq_r <= seq_r;
      if (seq_r != chk_seq_r) begin
         chk_len_r <= '0;
      end else begin
         chk_len_r <= chk_len_r + 1'b1;
      end
   end
end

a_wait_core_gated: assert property (@(posedge CLK_IN) disable iff (!NRST_IN || !POR_N_IN)
   mode_r == RPMSS_WAIT |-> !CORE_CLK_EN_OUT && PERIPH_CLK_EN_OUT) else $error("wait clocks wrong");
a_run_clocks_on: assert property (@(posedge CLK_IN) disable iff (!NRST_IN || !POR_N_IN)
   mode_r == RPMSS_RUN && CORE_RST_N_OUT |-> CORE_CLK_EN_OUT && PERIPH_CLK_EN_OUT) else $error("run clocks off");
a_wait_irq_wake: assert property (@(posedge CLK_IN) disable iff (!NRST_IN || !POR_N_IN)
   mode_r == RPMSS_WAIT && PERIPH_IRQ_IN && sync_rst_n |=> mode_r == RPMSS_RUN) else $error("no wake");
a_stop_only_srcs: assert property (@(posedge CLK_IN) disable iff (!NRST_IN || !POR_N_IN)
   mode_r == RPMSS_STOP && !CAN_ACT_IN && !NCLK_IRQ_IN && sync_rst_n |=> mode_r == RPMSS_STOP) else $error("bad wake");
a_stop_disabled: assert property (@(posedge CLK_IN) disable iff (!NRST_IN || !POR_N_IN)
   mode_r == RPMSS_RUN && stop_dis_r && !WAIT_REQ_IN |=> mode_r == RPMSS_RUN) else $error("stop not blocked");
a_perm_holds: assert property (@(posedge CLK_IN) disable iff (!NRST_IN || !POR_N_IN)
   perm_r && sync_rst_n |=> perm_r && $stable(wait_dis_r) && $stable(stop_dis_r)) else $error("perm lost");
a_stage_length: assert property (@(posedge CLK_IN) disable iff (!NRST_IN || !POR_N_IN)
   $rose(seq_r == RPMSS_RST_PERIPH) && sync_rst_n |-> (seq_r == RPMSS_RST_PERIPH)[*8]) else $error("stage short");
a_secure_boot: assert property (@(posedge CLK_IN) disable iff (!NRST_IN || !POR_N_IN)
   secure_r |-> BOOT_ADDR_OUT == RPMSS_SEC_BOOT_ADDR && !DEBUG_EN_OUT && DBG_RD_DIS_OUT) else $error("secure boot");
a_rd_dis_stable: assert property (@(posedge CLK_IN) disable iff (!NRST_IN || !POR_N_IN)
   sec_taken_r && sync_rst_n |=> $stable(DBG_RD_DIS_OUT)) else $error("rd dis changed");

a_por_stretch: assert property (@(posedge CLK_IN) disable iff (!NRST_IN || !POR_N_IN)
   seq_r == RPMSS_RST_CLK && chk_seq_r == RPMSS_RST_POR && !por_done_r |-> chk_len_r >= RPMSS_CNT_W'(POR_CYCLES))
   else $error("stretch short");
a_clk_stage_len: assert property (@(posedge CLK_IN) disable iff (!NRST_IN || !POR_N_IN)
   seq_r == RPMSS_RST_PERIPH && chk_seq_r == RPMSS_RST_CLK |-> chk_len_r == RPMSS_CNT_W'(RPMSS_STAGE_CYC - 1))
   else $error("clock stage length");
a_periph_stage_len: assert property (@(posedge CLK_IN) disable iff (!NRST_IN || !POR_N_IN)
   seq_r == RPMSS_RST_CORE && chk_seq_r == RPMSS_RST_PERIPH |-> chk_len_r == RPMSS_CNT_W'(RPMSS_STAGE_CYC - 1))
   else $error("peripheral stage length");
a_core_stage_len: assert property (@(posedge CLK_IN) disable iff (!NRST_IN || !POR_N_IN)
   seq_r == RPMSS_RST_DONE && chk_seq_r == RPMSS_RST_CORE |-> chk_len_r == RPMSS_CNT_W'(RPMSS_STAGE_CYC - 1))
   else $error("core stage length");
a_core_rst_order: assert property (@(posedge CLK_IN) disable iff (!NRST_IN || !POR_N_IN)
   CORE_RST_N_OUT |-> PERIPH_RST_N_OUT && SYSINT_CLK_EN_OUT)
   else $error("core released early");
a_rst_sync_hold: assert property (@(posedge CLK_IN) disable iff (!NRST_IN || !POR_N_IN)
   !sync_rst_n |=> seq_r == RPMSS_RST_POR && !CORE_RST_N_OUT && !PERIPH_RST_N_OUT)
   else $error("reset not held");
a_wdog_reset: assert property (@(posedge CLK_IN) disable iff (!NRST_IN || !POR_N_IN)
   WDOG_RST_IN |=> !CORE_RST_N_OUT && seq_r == RPMSS_RST_POR)
   else $error("watchdog reset missed");
a_sw_reset: assert property (@(posedge CLK_IN) disable iff (!NRST_IN || !POR_N_IN)
   ap_wr_r && ap_addr_r == RPMSS_CTRL_ADDR[RPMSS_ADDR_W-1:0] && HWDATA_IN[RPMSS_BIT_SWRST] && sync_rst_n |=> !sync_rst_n)
   else $error("software reset missed");
a_can_drop_first: assert property (@(posedge CLK_IN) disable iff (!NRST_IN || !POR_N_IN)
   mode_r == RPMSS_STOP && CAN_ACT_IN && sync_rst_n |=> CAN_DROP_OUT && mode_r == RPMSS_RUN)
   else $error("wake frame kept");
a_wait_disabled: assert property (@(posedge CLK_IN) disable iff (!NRST_IN || !POR_N_IN)
   mode_r == RPMSS_RUN && wait_dis_r && !STOP_REQ_IN |=> mode_r == RPMSS_RUN)
   else $error("wait not blocked");
a_perm_cleared: assert property (@(posedge CLK_IN) disable iff (!NRST_IN || !POR_N_IN)
   !sync_rst_n |=> !perm_r && !wait_dis_r && !stop_dis_r)
   else $error("disable kept over reset");
a_periph_clk_on: assert property (@(posedge CLK_IN) disable iff (!NRST_IN || !POR_N_IN)
   SYSINT_CLK_EN_OUT && mode_r != RPMSS_STOP |-> PERIPH_CLK_EN_OUT)
   else $error("peripheral clock off");
a_sec_sample: assert property (@(posedge CLK_IN) disable iff (!NRST_IN || !POR_N_IN)
   seq_r == RPMSS_RST_PERIPH && !sec_taken_r && sync_rst_n |=> SECURE_OUT == ($past(SEC_BYTES_IN) != RPMSS_UNSEC_WORD))
   else $error("security not sampled");
a_secure_blocks: assert property (@(posedge CLK_IN) disable iff (!NRST_IN || !POR_N_IN)
   SECURE_OUT |-> !EXT_PSPACE_EN_OUT && !DEBUG_EN_OUT)
   else $error("secure access open");
a_unsec_boot: assert property (@(posedge CLK_IN) disable iff (!NRST_IN || !POR_N_IN)
   !SECURE_OUT |-> BOOT_MODE_OUT != 2'(RPMSS_BOOT_SEC))
   else $error("unsecured boot mode");
a_tap_always: assert property (@(posedge CLK_IN) disable iff (!NRST_IN || !POR_N_IN)
   TAP_EN_OUT)
   else $error("test port off");

c_enter_wait: cover property (@(posedge CLK_IN) mode_r == RPMSS_RUN ##1 mode_r == RPMSS_WAIT);
c_enter_stop: cover property (@(posedge CLK_IN) mode_r == RPMSS_RUN ##1 mode_r == RPMSS_STOP);
c_secure_boot: cover property (@(posedge CLK_IN) sec_taken_r && SECURE_OUT);
c_can_wake: cover property (@(posedge CLK_IN) mode_r == RPMSS_STOP && CAN_ACT_IN);
c_core_out: cover property (@(posedge CLK_IN) $rose(CORE_RST_N_OUT));
endmodule
`default_nettype wire

// ==== test_reset_power_mode_security_seq.sv ====
// Self-checking bench for the reset, power mode and security sequencer
`timescale 1ns/1ps
`default_nettype none
module test_reset_power_mode_security_seq;
   import rpmss_pkg::*;
   localparam int POR_N = 40;
   logic clk, nrst, por_n, wdog, strap, stop_c, wait_c, irq, nirq, can, sec_cfg, stop_r, wait_r;
   logic hsel, hwrite, hrdy, hresp, core_ce, per_ce, sysint_ce, per_rn, core_rn, drop, secure, ext_en, dbg_en, rd_dis;
   logic tap;
   logic [15:0] key, sec_b;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans, boot, eb;
   logic [2:0] hsize;
   logic [23:0] baddr;
   int error_cnt, checks_done, cyc, n, p, exp_ctrl, s;
   ////////////////////////////////////////
   rpmss_top #(.POR_CYCLES(POR_N)) dut (.CLK_IN(clk), .NRST_IN(nrst), .POR_N_IN(por_n), .WDOG_RST_IN(wdog),
      .EXT_BOOT_STRAP_IN(strap), .SEC_BYTES_IN(sec_b), .STOP_REQ_IN(stop_r), .WAIT_REQ_IN(wait_r),
      .PERIPH_IRQ_IN(irq), .NCLK_IRQ_IN(nirq), .CAN_ACT_IN(can), .HSEL_IN(hsel), .HADDR_IN(haddr),
      .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(hsize), .HWDATA_IN(hwdata), .HREADY_IN(hrdy),
      .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hrdy), .HRESP_OUT(hresp), .CORE_CLK_EN_OUT(core_ce),
      .PERIPH_CLK_EN_OUT(per_ce), .SYSINT_CLK_EN_OUT(sysint_ce), .PERIPH_RST_N_OUT(per_rn),
      .CORE_RST_N_OUT(core_rn), .CAN_DROP_OUT(drop), .SECURE_OUT(secure), .EXT_PSPACE_EN_OUT(ext_en),
      .DEBUG_EN_OUT(dbg_en), .DBG_RD_DIS_OUT(rd_dis), .TAP_EN_OUT(tap), .BOOT_MODE_OUT(boot),
      .BOOT_ADDR_OUT(baddr));
   rpmss_far_model far (.clk_in(clk), .secure_in(sec_cfg), .key_in(key), .stop_cmd_in(stop_c),
      .wait_cmd_in(wait_c), .sec_bytes_out(sec_b), .stop_req_out(stop_r), .wait_req_out(wait_r));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         error_cnt++;
         results();
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic results();
      $display("Checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic step(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= RPMSS_HTRANS_NONSEQ;
      haddr <= a;
      hwrite <= wr;
      @(posedge clk);
      while (hrdy !== 1'b1) @(posedge clk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge clk);
      while (hrdy !== 1'b1) @(posedge clk);
      #1;
      rd = hrdata;
      chk(hresp, 1'b0);
      chk(hrdy, 1'b1);
   endtask
   task automatic wr_ctrl(input logic [31:0] wd);
      ahb(1'b1, RPMSS_CTRL_ADDR, wd);
      if (exp_ctrl[2] == 1'b0) exp_ctrl = wd & 7;
   endtask
   // Counts cycles to core release; peripheral release 32 before it
   task automatic settle(input int lo);
      n = 0;
      p = 0;
      while (core_rn !== 1'b1 && n < 400) begin
         step(1);
         n++;
         if (per_rn === 1'b1 && p == 0) p = n;
         if (n == 8) chk({sysint_ce, per_rn}, {lo < 100, 1'b0});
      end
      chk(n >= lo && n <= lo + 10, 1'b1);
      chk(n - p >= 31 && n - p <= 33, 1'b1);
   endtask
   task automatic do_reset(input logic por, input int lo);
      @(posedge clk);
      nrst <= 1'b0;
      por_n <= ~por;
      step(10);
      nrst <= 1'b1;
      por_n <= 1'b1;
      exp_ctrl = 0;
      settle(lo);
   endtask
   initial begin
      {nrst, por_n, wdog, strap, stop_c, wait_c, irq, nirq, can, sec_cfg, hsel, hwrite} = '0;
      {key, haddr, hwdata, htrans} = '0;
      hsize = 3'h2;
      s = $urandom(32'h38bfe6b5);
      do_reset(1'b1, POR_N + 96);
      chk({core_ce, per_ce, sysint_ce, tap}, 4'hf);
      ahb(1'b0, RPMSS_STAT_ADDR, 32'h0);
      chk(rd[4:0], 5'h0);
      wait_c <= 1'b1;
      step(4);
      chk({core_ce, per_ce}, 2'b01);
      irq <= 1'b1;
      step(3);
      chk(core_ce, 1'b1);
      wait_c <= 1'b0;
      irq <= 1'b0;
      for (int i = 0; i < 2; i++) begin
         stop_c <= 1'b1;
         step(4);
         irq <= 1'b1;
         step(3);
         chk(core_ce, 1'b0);
         irq <= 1'b0;
         can <= (i == 0);
         nirq <= (i == 1);
         stop_c <= 1'b0;
         step(3);
         chk({core_ce, drop}, {1'b1, i == 0});
         can <= 1'b0;
         nirq <= 1'b0;
         step(2);
         can <= 1'b1;
         step(2);
         chk(drop, 1'b0);
         can <= 1'b0;
      end
      for (int v = 0; v < 4; v++) begin
         wr_ctrl(v);
         wait_c <= 1'b1;
         step(4);
         chk(core_ce, exp_ctrl[0]);
         wait_c <= 1'b0;
         irq <= 1'b1;
         step(2);
         irq <= 1'b0;
      end
      stop_c <= 1'b1;
      step(4);
      chk(core_ce, exp_ctrl[1]);
      stop_c <= 1'b0;
      wr_ctrl(32'h7);
      wr_ctrl(32'h0);
      ahb(1'b0, RPMSS_CTRL_ADDR, 32'h0);
      chk(rd[2:0], exp_ctrl[2:0]);
      wdog <= 1'b1;
      step(1);
      wdog <= 1'b0;
      step(3);
      chk(core_rn, 1'b0);
      exp_ctrl = 0;
      settle(90);
      ahb(1'b0, RPMSS_CTRL_ADDR, 32'h0);
      chk(rd[2:0], exp_ctrl[2:0]);
      ahb(1'b1, RPMSS_CTRL_ADDR, 32'h8);
      step(3);
      chk(core_rn, 1'b0);
      settle(90);
      ahb(1'b1, 32'h0000_0008, $urandom);
      ahb(1'b0, 32'h0000_0008, 32'h0);
      chk(rd, 32'h0);
      for (int i = 0; i < 4; i++) begin
         s = i / 2;
         eb = s ? 2'h2 : {1'b0, i[0]};
         sec_cfg <= s[0];
         strap <= i[0];
         key <= $urandom;
         do_reset(1'b0, 96);
         chk({secure, rd_dis, ext_en, dbg_en, tap}, {s[0], s[0], ~s[0], ~s[0], 1'b1});
         chk(boot, eb);
         chk(baddr, s ? RPMSS_SEC_BOOT_ADDR : i[0] ? RPMSS_EXT_BOOT_ADDR : RPMSS_INT_BOOT_ADDR);
         sec_cfg <= ~s[0];
         step(3);
         chk(rd_dis, s[0]);
         ahb(1'b0, RPMSS_STAT_ADDR, 32'h0);
         chk(rd[4:2], {eb, s[0]});
      end
      results();
   end
endmodule
`default_nettype wire
